//--- verilog/scirx_pkg.sv
package scirx_pkg;
    // ==========================================
    // register word indices
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_DATA = 3'h1;
    localparam logic [2:0] ADDR_CTRL = 3'h2;
    localparam logic [2:0] ADDR_BAUD = 3'h3;
    localparam logic [2:0] ADDR_RX_FINE = 3'h4;
    localparam logic [2:0] ADDR_TX_FINE = 3'h5;
    // ==========================================
    // status bit positions
    localparam int ST_RX_FULL = 5;
    localparam int ST_IDLE = 4;
    localparam int ST_OVERRUN = 3;
    localparam int ST_NOISE = 2;
    localparam int ST_FRAMING = 1;
    localparam int ST_PARITY = 0;
    // ==========================================
    // control bit positions
    localparam int CT_RX_EN = 0;
    localparam int CT_TX_EN = 1;
    localparam int CT_WORD9 = 2;
    localparam int CT_WAKE = 3;
    localparam int CT_PAR_EN = 4;
    localparam int CT_PAR_SEL = 5;
    localparam int CT_MUTE = 6;
    localparam int CT_RX_IE = 7;
    localparam int CT_IDLE_IE = 8;
    localparam int CT_PAR_IE = 9;
    // ==========================================
    // baud select field positions
    localparam int BD_RX_LSB = 0;
    localparam int BD_TX_LSB = 3;
    localparam int BD_PR_LSB = 6;
    // ==========================================
    // reset values
    localparam logic [9:0] CTRL_RESET = 10'h000;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam logic [7:0] FINE_RESET = 8'h00;
    // ==========================================
    // oversampling and idle timing
    localparam logic [3:0] VOTE_A = 4'h7;
    localparam logic [3:0] VOTE_B = 4'h8;
    localparam logic [3:0] VOTE_C = 4'h9;
    localparam logic [7:0] IDLE_TICKS_8 = 8'd160;
    localparam logic [7:0] IDLE_TICKS_9 = 8'd176;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } scirx_state_type;

    // shared prescaler terminal count for 1, 3, 4, 13
    function automatic logic [3:0] prescale_last(input logic [1:0] sel);
        case (sel)
            2'd0: prescale_last = 4'd0;
            2'd1: prescale_last = 4'd2;
            2'd2: prescale_last = 4'd3;
            default: prescale_last = 4'd12;
        endcase
    endfunction
endpackage

//--- verilog/scirx_receiver.sv
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module scirx_receiver (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_serial_in,
    input wire logic cpu_irq_mask,
    output logic rx_irq,
    output logic tx_baud_tick
);
    typedef struct packed {
        logic [9:0] ctrl;
        logic [7:0] baud;
        logic [7:0] rx_fine;
        logic [7:0] tx_fine;
        logic [5:0] flags;
        logic [8:0] rx_buffer;
        logic [8:0] shifter;
        scirx_pkg::scirx_state_type state;
        logic [3:0] smp_cnt;
        logic [3:0] bit_cnt;
        logic [1:0] votes;
        logic noisy;
        logic [7:0] idle_cnt;
        logic idle_armed;
        logic seq_armed;
        logic line_prev;
        logic [3:0] pr_cnt;
        logic [6:0] rx_div;
        logic [6:0] tx_div;
        logic [7:0] rx_fcnt;
        logic [7:0] tx_fcnt;
        logic tx_tick;
        logic irq;
        logic wait_n;
        logic [31:0] rdata;
    } scirx_regs_type;

    scirx_regs_type st_reg;
    scirx_regs_type st_next;

    // ==========================================
    // helpers
    function automatic logic div_hit(input logic [6:0] cnt, input logic [2:0] sel);
        div_hit = (cnt == 7'((8'd1 << sel) - 8'd1));
    endfunction

    function automatic logic fine_hit(input logic [7:0] cnt, input logic [7:0] fine);
        fine_hit = (fine == 8'h00) || (cnt == fine - 8'd1);
    endfunction

    logic pr_tick;
    logic rx_tick;
    logic take;
    logic st_rd;
    logic dt_rd;
    logic word9;
    logic vote;
    logic disagree;
    logic done;
    logic idle_evt;
    logic addr_mark;
    logic accept;
    logic par_bad;
    logic [8:0] word;
    logic [3:0] nbits;
    logic [7:0] idle_lim;

    always_comb begin
        st_next = st_reg;
        word9 = st_reg.ctrl[scirx_pkg::CT_WORD9];
        nbits = word9 ? scirx_pkg::BITS_9 : scirx_pkg::BITS_8;
        idle_lim = word9 ? scirx_pkg::IDLE_TICKS_9 : scirx_pkg::IDLE_TICKS_8;
        // ==========================================
        // baud generation
        pr_tick = (st_reg.pr_cnt == scirx_pkg::prescale_last(st_reg.baud[7:6]));
        rx_tick = 1'b0;
        st_next.tx_tick = 1'b0;
        if (pr_tick) begin
            st_next.pr_cnt = 4'd0;
            if (div_hit(st_reg.rx_div, st_reg.baud[2:0])) begin
                st_next.rx_div = 7'd0;
                rx_tick = fine_hit(st_reg.rx_fcnt, st_reg.rx_fine);
                st_next.rx_fcnt = rx_tick ? 8'd0 : st_reg.rx_fcnt + 8'd1;
            end else begin
                st_next.rx_div = st_reg.rx_div + 7'd1;
            end
            if (div_hit(st_reg.tx_div, st_reg.baud[5:3])) begin
                st_next.tx_div = 7'd0;
                st_next.tx_tick = fine_hit(st_reg.tx_fcnt, st_reg.tx_fine);
                st_next.tx_fcnt = st_next.tx_tick ? 8'd0 : st_reg.tx_fcnt + 8'd1;
            end else begin
                st_next.tx_div = st_reg.tx_div + 7'd1;
            end
        end else begin
            st_next.pr_cnt = st_reg.pr_cnt + 4'd1;
        end
        rx_tick = rx_tick && st_reg.ctrl[scirx_pkg::CT_RX_EN];
        // ==========================================
        // bus slave
        take = (avs_read || avs_write) && st_reg.wait_n;
        st_rd = take && avs_read && (avs_address == scirx_pkg::ADDR_STATUS);
        dt_rd = take && avs_read && (avs_address == scirx_pkg::ADDR_DATA);
        st_next.wait_n = (avs_read || avs_write) && !st_reg.wait_n;
        st_next.rdata = 32'h0000_0000;
        if (avs_read && !st_reg.wait_n) begin
            case (avs_address)
                scirx_pkg::ADDR_STATUS: st_next.rdata = {26'h000_0000, st_reg.flags};
                scirx_pkg::ADDR_DATA: st_next.rdata = {23'h00_0000, st_reg.rx_buffer};
                scirx_pkg::ADDR_CTRL: st_next.rdata = {22'h00_0000, st_reg.ctrl};
                scirx_pkg::ADDR_BAUD: st_next.rdata = {24'h00_0000, st_reg.baud};
                scirx_pkg::ADDR_RX_FINE: st_next.rdata = {24'h00_0000, st_reg.rx_fine};
                scirx_pkg::ADDR_TX_FINE: st_next.rdata = {24'h00_0000, st_reg.tx_fine};
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end
        if (take && avs_write) begin
            case (avs_address)
                scirx_pkg::ADDR_CTRL: st_next.ctrl = avs_writedata[9:0];
                scirx_pkg::ADDR_BAUD: st_next.baud = avs_writedata[7:0];
                scirx_pkg::ADDR_RX_FINE: st_next.rx_fine = avs_writedata[7:0];
                scirx_pkg::ADDR_TX_FINE: st_next.tx_fine = avs_writedata[7:0];
                default: st_next.baud = st_reg.baud;
            endcase
        end
        // status then data read clears all receive flags
        if (st_rd) begin
            st_next.seq_armed = 1'b1;
        end else if (dt_rd && st_reg.seq_armed) begin
            st_next.seq_armed = 1'b0;
            st_next.flags = 6'h00;
        end
        // ==========================================
        // receive sampling
        vote = 1'b0;
        disagree = 1'b0;
        done = 1'b0;
        if (rx_tick) begin
            st_next.line_prev = rx_serial_in;
            st_next.smp_cnt = st_reg.smp_cnt + 4'd1;
            if (st_reg.smp_cnt == scirx_pkg::VOTE_A) begin
                st_next.votes[0] = rx_serial_in;
            end
            if (st_reg.smp_cnt == scirx_pkg::VOTE_B) begin
                st_next.votes[1] = rx_serial_in;
            end
            // majority of three centre samples
            vote = (st_reg.votes[0] & st_reg.votes[1]) | (st_reg.votes[0] & rx_serial_in)
                | (st_reg.votes[1] & rx_serial_in);
            disagree = (st_reg.votes[0] != st_reg.votes[1])
                || (st_reg.votes[1] != rx_serial_in);
            if (st_reg.smp_cnt == scirx_pkg::VOTE_C && st_reg.state != scirx_pkg::RX_IDLE) begin
                st_next.noisy = st_reg.noisy | disagree;
            end
            case (st_reg.state)
                scirx_pkg::RX_IDLE: begin
                    if (st_reg.line_prev && !rx_serial_in) begin
                        st_next.state = scirx_pkg::RX_START;
                        st_next.smp_cnt = 4'd1;
                        st_next.noisy = 1'b0;
                        st_next.bit_cnt = 4'd0;
                    end
                end
                scirx_pkg::RX_START: begin
                    if (st_reg.smp_cnt == scirx_pkg::VOTE_C) begin
                        if (vote) begin
                            st_next.state = scirx_pkg::RX_IDLE;
                        end
                    end else if (st_reg.smp_cnt == 4'hf) begin
                        st_next.state = scirx_pkg::RX_DATA;
                    end
                end
                scirx_pkg::RX_DATA: begin
                    if (st_reg.smp_cnt == scirx_pkg::VOTE_C) begin
                        st_next.shifter = {vote, st_reg.shifter[8:1]};
                        st_next.bit_cnt = st_reg.bit_cnt + 4'd1;
                    end else if (st_reg.smp_cnt == 4'hf && st_reg.bit_cnt == nbits) begin
                        st_next.state = scirx_pkg::RX_STOP;
                    end
                end
                scirx_pkg::RX_STOP: begin
                    if (st_reg.smp_cnt == scirx_pkg::VOTE_C) begin
                        done = 1'b1;
                        st_next.state = scirx_pkg::RX_IDLE;
                    end
                end
                default: st_next.state = scirx_pkg::RX_IDLE;
            endcase
        end
        // ==========================================
        // character completion
        word = word9 ? st_reg.shifter : {1'b0, st_reg.shifter[8:1]};
        addr_mark = st_reg.ctrl[scirx_pkg::CT_PAR_EN] ? word[nbits - 4'd2]
            : word[nbits - 4'd1];
        par_bad = st_reg.ctrl[scirx_pkg::CT_PAR_EN]
            && ((^word) != st_reg.ctrl[scirx_pkg::CT_PAR_SEL]);
        accept = done && (!st_reg.ctrl[scirx_pkg::CT_MUTE]
            || (st_reg.ctrl[scirx_pkg::CT_WAKE] && addr_mark));
        if (done) begin
            st_next.idle_armed = 1'b1;
        end
        if (accept) begin
            st_next.ctrl[scirx_pkg::CT_MUTE] = 1'b0;
            if (st_reg.flags[scirx_pkg::ST_RX_FULL]) begin
                st_next.flags[scirx_pkg::ST_OVERRUN] = 1'b1;
            end else begin
                st_next.rx_buffer = word;
                st_next.flags[scirx_pkg::ST_RX_FULL] = 1'b1;
                st_next.flags[scirx_pkg::ST_NOISE] = st_reg.noisy | disagree;
                st_next.flags[scirx_pkg::ST_FRAMING] = !vote;
                st_next.flags[scirx_pkg::ST_PARITY] = par_bad;
            end
        end
        // ==========================================
        // idle line detection
        idle_evt = 1'b0;
        if (rx_tick) begin
            if (!rx_serial_in || st_reg.state != scirx_pkg::RX_IDLE) begin
                st_next.idle_cnt = 8'd0;
            end else if (st_reg.idle_cnt != idle_lim) begin
                st_next.idle_cnt = st_reg.idle_cnt + 8'd1;
                idle_evt = (st_reg.idle_cnt == idle_lim - 8'd1) && st_reg.idle_armed;
            end
        end
        if (idle_evt) begin
            st_next.idle_armed = 1'b0;
            if (!st_reg.ctrl[scirx_pkg::CT_MUTE]) begin
                st_next.flags[scirx_pkg::ST_IDLE] = 1'b1;
            end else if (!st_reg.ctrl[scirx_pkg::CT_WAKE]) begin
                st_next.ctrl[scirx_pkg::CT_MUTE] = 1'b0;
            end
        end
        // ==========================================
        // interrupt request
        st_next.irq = !cpu_irq_mask && !st_next.ctrl[scirx_pkg::CT_MUTE]
            && ((st_next.ctrl[scirx_pkg::CT_RX_IE] && (st_next.flags[scirx_pkg::ST_RX_FULL]
            || st_next.flags[scirx_pkg::ST_OVERRUN]))
            || (st_next.ctrl[scirx_pkg::CT_IDLE_IE] && st_next.flags[scirx_pkg::ST_IDLE])
            || (st_next.ctrl[scirx_pkg::CT_PAR_IE] && st_next.flags[scirx_pkg::ST_PARITY]));
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.ctrl <= scirx_pkg::CTRL_RESET;
            st_reg.baud <= scirx_pkg::BAUD_RESET;
            st_reg.rx_fine <= scirx_pkg::FINE_RESET;
            st_reg.tx_fine <= scirx_pkg::FINE_RESET;
            st_reg.state <= scirx_pkg::RX_IDLE;
            st_reg.idle_armed <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata = st_reg.rdata;
    assign avs_waitrequest = !st_reg.wait_n;
    assign rx_irq = st_reg.irq;
    assign tx_baud_tick = st_reg.tx_tick;

    // ==========================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_clear_seq;
        $fell(st_reg.flags[scirx_pkg::ST_RX_FULL]) |-> $past(dt_rd && st_reg.seq_armed);
    endproperty
    a_clear_seq: assert property (p_clear_seq) else $error("full flag fell without sequence");

    property p_overrun;
        accept && st_reg.flags[scirx_pkg::ST_RX_FULL] |=>
            st_reg.flags[scirx_pkg::ST_OVERRUN] && $stable(st_reg.rx_buffer);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged or buffer lost");

    property p_noise;
        accept && !st_reg.flags[scirx_pkg::ST_RX_FULL] && st_reg.noisy |=>
            st_reg.flags[scirx_pkg::ST_NOISE] && st_reg.flags[scirx_pkg::ST_RX_FULL];
    endproperty
    a_noise: assert property (p_noise) else $error("noise flag missing");

    property p_framing;
        accept && !st_reg.flags[scirx_pkg::ST_RX_FULL] && !vote |=>
            st_reg.flags[scirx_pkg::ST_FRAMING] && st_reg.rx_buffer == $past(word);
    endproperty
    a_framing: assert property (p_framing) else $error("framing error not reported");

    property p_mute_quiet;
        st_reg.ctrl[scirx_pkg::CT_MUTE] && !accept |=> !$rose(st_reg.flags[scirx_pkg::ST_RX_FULL])
            && !$rose(st_reg.flags[scirx_pkg::ST_IDLE])
            && !(st_reg.irq && st_reg.ctrl[scirx_pkg::CT_MUTE]);
    endproperty
    a_mute_quiet: assert property (p_mute_quiet) else $error("muted receiver set a flag");

    property p_idle_wake;
        idle_evt && st_reg.ctrl[scirx_pkg::CT_MUTE] && !st_reg.ctrl[scirx_pkg::CT_WAKE] |=>
            !st_reg.ctrl[scirx_pkg::CT_MUTE] && !$rose(st_reg.flags[scirx_pkg::ST_IDLE]);
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");

    property p_addr_wake;
        done && st_reg.ctrl[scirx_pkg::CT_MUTE] && st_reg.ctrl[scirx_pkg::CT_WAKE] && addr_mark
            && !st_reg.flags[scirx_pkg::ST_RX_FULL] |=> !st_reg.ctrl[scirx_pkg::CT_MUTE]
            && st_reg.flags[scirx_pkg::ST_RX_FULL];
    endproperty
    a_addr_wake: assert property (p_addr_wake) else $error("address mark wake failed");

    property p_idle_len;
        idle_evt |-> st_reg.idle_cnt == idle_lim - 8'd1 && rx_serial_in;
    endproperty
    a_idle_len: assert property (p_idle_len) else $error("idle detected early");

    property p_bus_ack;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("waitrequest timing wrong");

    c_overrun: cover property (accept && st_reg.flags[scirx_pkg::ST_RX_FULL]);
    c_idle: cover property (idle_evt && !st_reg.ctrl[scirx_pkg::CT_MUTE]);
    c_addr_wake: cover property (accept && st_reg.ctrl[scirx_pkg::CT_MUTE]);
    c_clear: cover property (dt_rd && st_reg.seq_armed);
endmodule

//--- verification/scirx_remote_node.sv
`timescale 1ns/1ps
module scirx_remote_node #(
    parameter int BIT_CYC = 16
) (
    input wire logic clock,
    output logic rx_line
);
    // ==========================================
    // line idles high between frames
    initial begin
        rx_line = 1'b1;
    end
    // ==========================================
    // start, nbits lsb first, stop; one sample of one bit may be flipped
    task automatic send(input logic [9:0] bits, input int nbits, input logic stop_val,
        input int glitch);
        logic v;
        for (int i = 0; i < nbits + 2; i++) begin
            v = (i == 0) ? 1'b0 : ((i <= nbits) ? bits[i-1] : stop_val);
            for (int c = 0; c < BIT_CYC; c++) begin
                @(posedge clock);
                rx_line <= (i == glitch + 1 && c == 8) ? ~v : v;
            end
        end
        @(posedge clock);
        rx_line <= 1'b1;
    endtask
endmodule

//--- verification/scirx_receiver_test.sv
`timescale 1ns/1ps
module scirx_receiver_test;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic rx_line;
    logic cpu_irq_mask = 1'b0;
    logic rx_irq;
    logic tx_baud_tick;
    logic [31:0] rd;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    localparam logic [31:0] S_FULL = 32'h1 << scirx_pkg::ST_RX_FULL;
    localparam logic [31:0] S_IDLE = 32'h1 << scirx_pkg::ST_IDLE;
    localparam logic [31:0] S_OVR = 32'h1 << scirx_pkg::ST_OVERRUN;
    localparam logic [31:0] S_NOISE = 32'h1 << scirx_pkg::ST_NOISE;
    localparam logic [31:0] S_FRM = 32'h1 << scirx_pkg::ST_FRAMING;
    localparam logic [31:0] S_PAR = 32'h1 << scirx_pkg::ST_PARITY;
    localparam logic [31:0] RXEN = 32'h1 << scirx_pkg::CT_RX_EN;
    localparam logic [31:0] TXEN = 32'h1 << scirx_pkg::CT_TX_EN;
    localparam logic [31:0] W9 = 32'h1 << scirx_pkg::CT_WORD9;
    localparam logic [31:0] PEN = 32'h1 << scirx_pkg::CT_PAR_EN;
    localparam logic [31:0] PSEL = 32'h1 << scirx_pkg::CT_PAR_SEL;
    localparam logic [31:0] MUTE = 32'h1 << scirx_pkg::CT_MUTE;
    localparam logic [31:0] RX_IRQ_ENABLE = 32'h1 << scirx_pkg::CT_RX_IE;
    localparam logic [31:0] IIE = 32'h1 << scirx_pkg::CT_IDLE_IE;
    localparam logic [31:0] PIE = 32'h1 << scirx_pkg::CT_PAR_IE;
    localparam logic [31:0] MUTED = RXEN | W9 | PEN | MUTE | RX_IRQ_ENABLE | (32'h1 << scirx_pkg::CT_WAKE);
    localparam logic [2:0] A_ST = scirx_pkg::ADDR_STATUS;
    localparam logic [2:0] A_DT = scirx_pkg::ADDR_DATA;
    localparam logic [2:0] A_CT = scirx_pkg::ADDR_CTRL;

    always #2 clock = ~clock;

    scirx_receiver i_scirx_receiver (
        .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx_serial_in(rx_line), .cpu_irq_mask(cpu_irq_mask), .rx_irq(rx_irq),
        .tx_baud_tick(tx_baud_tick)
    );
    scirx_remote_node i_scirx_remote_node (.clock(clock), .rx_line(rx_line));

    // ==========================================
    // reporting and bus access
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rchk(input string name, input logic [2:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(name, exp, rd);
    endtask
    // ==========================================
    // scenarios
    task automatic rx_case(input logic [31:0] ctrl, input logic [9:0] bits, input int nbits,
        input logic stop_val, input int glitch, input logic [31:0] st, input logic [31:0] dat);
        logic irq_exp;
        repeat (200) @(posedge clock);
        bus(1'b0, A_ST, 32'h0000_0000);
        bus(1'b0, A_DT, 32'h0000_0000);
        bus(1'b1, A_CT, ctrl);
        i_scirx_remote_node.send(bits, nbits, stop_val, glitch);
        irq_exp = (ctrl[scirx_pkg::CT_RX_IE] && st != 0)
            || (ctrl[scirx_pkg::CT_PAR_IE] && st[scirx_pkg::ST_PARITY]);
        chk("irq", {31'h0, irq_exp}, {31'h0, rx_irq});
        rchk("status", A_ST, st);
        rchk("data", A_DT, dat);
        rchk("cleared", A_ST, 32'h0000_0000);
    endtask
    task automatic t_order_overrun();
        bus(1'b1, A_CT, RXEN | RX_IRQ_ENABLE);
        i_scirx_remote_node.send(10'h0A5, 8, 1'b1, 99);
        rchk("data first", A_DT, 32'h0000_00A5);
        rchk("still full", A_ST, S_FULL);
        rchk("data", A_DT, 32'h0000_00A5);
        rchk("cleared", A_ST, 32'h0000_0000);
        i_scirx_remote_node.send(10'h011, 8, 1'b1, 99);
        i_scirx_remote_node.send(10'h022, 8, 1'b1, 99);
        chk("overrun irq", 32'h0000_0001, {31'h0, rx_irq});
        rchk("overrun status", A_ST, S_FULL | S_OVR);
        rchk("kept data", A_DT, 32'h0000_0011);
        rchk("overrun cleared", A_ST, 32'h0000_0000);
    endtask
    task automatic t_idle();
        bus(1'b0, A_ST, 32'h0000_0000);
        bus(1'b0, A_DT, 32'h0000_0000);
        cpu_irq_mask <= 1'b1;
        bus(1'b1, A_CT, RXEN | IIE);
        i_scirx_remote_node.send(10'h042, 8, 1'b1, 99);
        rchk("status", A_ST, S_FULL);
        rchk("data", A_DT, 32'h0000_0042);
        bus(1'b1, A_CT, RXEN | IIE | MUTE);
        repeat (110) @(posedge clock);
        rchk("still muted", A_CT, RXEN | IIE | MUTE);
        repeat (40) @(posedge clock);
        rchk("woken", A_CT, RXEN | IIE);
        rchk("no idle", A_ST, 32'h0000_0000);
        i_scirx_remote_node.send(10'h042, 8, 1'b1, 99);
        rchk("status", A_ST, S_FULL);
        rchk("data", A_DT, 32'h0000_0042);
        repeat (200) @(posedge clock);
        chk("masked irq", 32'h0000_0000, {31'h0, rx_irq});
        cpu_irq_mask <= 1'b0;
        repeat (3) @(posedge clock);
        chk("idle irq", 32'h0000_0001, {31'h0, rx_irq});
        rchk("idle", A_ST, S_IDLE);
        rchk("data", A_DT, 32'h0000_0042);
    endtask
    task automatic t_baud(input logic [31:0] sel, input logic [31:0] fine, input int period);
        int n;
        bus(1'b1, A_CT, 32'h0000_0000);
        bus(1'b1, scirx_pkg::ADDR_BAUD, sel);
        bus(1'b1, scirx_pkg::ADDR_TX_FINE, fine);
        bus(1'b1, A_CT, TXEN);
        while (tx_baud_tick !== 1'b1) begin
            @(posedge clock);
        end
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (tx_baud_tick !== 1'b1);
        chk("tick period", 32'(period), 32'(n));
    endtask
    // ==========================================
    // main sequence and timeout
    initial begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        t_order_overrun();
        rchk("unmapped", 3'h6, 32'h0000_0000);
        rx_case(RXEN, 10'h03C, 8, 1'b1, 2, S_FULL | S_NOISE, 32'h0000_003C);
        rx_case(RXEN, 10'h000, 8, 1'b0, 99, S_FULL | S_FRM, 32'h0000_0000);
        rx_case(RXEN, 10'h05A, 8, 1'b0, 99, S_FULL | S_FRM, 32'h0000_005A);
        rx_case(RXEN | PEN, 10'h035, 8, 1'b1, 99, S_FULL, 32'h0000_0035);
        rx_case(RXEN | PEN | PSEL | PIE, 10'h035, 8, 1'b1, 99, S_FULL | S_PAR,
            32'h0000_0035);
        rx_case(RXEN | W9 | RX_IRQ_ENABLE, 10'h1A5, 9, 1'b1, 99, S_FULL, 32'h0000_01A5);
        rx_case(RXEN | W9 | PEN, 10'h081, 9, 1'b1, 99, S_FULL, 32'h0000_0081);
        rx_case(MUTED, 10'h105, 9, 1'b1, 99, 32'h0000_0000, 32'h0000_0081);
        rchk("muted", A_CT, MUTED);
        rx_case(MUTED, 10'h081, 9, 1'b1, 99, S_FULL, 32'h0000_0081);
        rchk("address wake", A_CT, MUTED & ~MUTE);
        repeat (200) @(posedge clock);
        t_idle();
        t_baud(32'h0000_00C8, 32'h0000_0003, 78);
        t_baud(32'h0000_0078, 32'h0000_0000, 384);
        end_sim();
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            end_sim();
        end
    end
endmodule
